// ### core/dpll_pkg.sv
// package for the digital pll with ripple cancellation
// assumes a single core_clk domain; loop clocks arrive as enables from pins
package dpll_pkg;
    // ==========================================
    // modulus counter sizing
    localparam int DPLL_KEXP_MIN = 3;              // smallest modulus exponent
    localparam int DPLL_KEXP_MAX = 17;             // largest modulus exponent
    localparam int DPLL_KW = 18;                   // counter width, holds 2^17
    localparam logic [4:0] DPLL_KEXP_RST = 5'h03;  // exponent value after reset
    localparam logic [DPLL_KW-1:0] DPLL_KCNT_RST = 18'h00004; // modulus count after reset
    // ==========================================
    // feedback divider sizing
    localparam int DPLL_NW = 8;                    // divide-by-n counter width
    localparam logic [DPLL_NW-1:0] DPLL_N_RST = 8'h00; // divider after reset
    // ==========================================
    // detector and wiring modes
    typedef enum logic [1:0] {
        DPLL_MODE_XOR_DIRECT,   // xor detector drives direction
        DPLL_MODE_EDGE_DIRECT,  // edge detector drives direction
        DPLL_MODE_XOR_CANCEL,   // xor drives enable, second msb drives direction
        DPLL_MODE_EDGE_CANCEL   // edge detector, counting in one half period only
    } dpll_mode_e;
endpackage : dpll_pkg

// ### core/dpll_modulus_counter.sv
// modulus-programmable up/down counter with carry and borrow pulses
// assumes count_tick is already synchronous to core_clk
`timescale 1ns/1ps
`default_nettype none
module dpll_modulus_counter
    import dpll_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // control
    input wire logic count_tick,     // one-cycle modulus counter clock event
    input wire logic count_enable,   // high allows counting
    input wire logic count_down,     // high counts down, low counts up
    input wire logic [4:0] kexp,     // modulus is two to this power
    // results
    output logic carry,
    output logic borrow,
    output logic [DPLL_KW-1:0] count
);
    // ==========================================
    // modulus limits, clamp exponent into range
    logic [4:0] kexp_clamped;
    logic [DPLL_KW-1:0] modulus_top;  // modulus minus one
    logic [DPLL_KW-1:0] half_modulus;
    always_comb begin
        kexp_clamped = kexp;  // out-of-range exponents clamp to the limits
        if (kexp < 5'(DPLL_KEXP_MIN)) begin
            kexp_clamped = 5'(DPLL_KEXP_MIN);
        end else if (kexp > 5'(DPLL_KEXP_MAX)) begin
            kexp_clamped = 5'(DPLL_KEXP_MAX);
        end
        modulus_top = (DPLL_KW'(1) << kexp_clamped) - DPLL_KW'(1);
        half_modulus = DPLL_KW'(1) << (kexp_clamped - 5'h01);
    end
    // ==========================================
    // counter, with reload to the midpoint on wrap
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            count <= DPLL_KCNT_RST;
            carry <= 1'b0;
            borrow <= 1'b0;
        end else begin
            carry <= 1'b0;  // pulses last one cycle only
            borrow <= 1'b0;
            if (count_tick && count_enable) begin
                if (count_down) begin
                    // down only with enable and direction high
                    if (count == DPLL_KW'(0)) begin
                        borrow <= 1'b1;
                        count <= half_modulus;
                    end else begin
                        count <= count - DPLL_KW'(1);
                    end
                end else begin
                    // up only with enable high and direction low
                    if (count >= modulus_top) begin
                        carry <= 1'b1;
                        count <= half_modulus;
                    end else begin
                        count <= count + DPLL_KW'(1);
                    end
                end
            end
            // enable low: count holds whatever direction shows
        end
    end
endmodule : dpll_modulus_counter
`default_nettype wire

// ### core/dpll_core.sv
// What this block does
// - enable low holds the modulus counter
// - count down when enable and direction high
// - count up when enable high, direction low
// - modulus is a power of two, 8 to 131072
// - small modulus wide range, fast pull-in
// - xor detector: carry and borrow cancel
// - edge detector, small modulus: msb duty ripple
// - modulus half clock ratio: ripple at output rate
// - cancel mode: xor drives counter enable
// - cancel mode: second msb drives direction
// - zero phase error keeps average count steady
// - net count proportional to phase error
// - edge cancel: pulses in one half period
// - cancel wiring trims error limit, halves gain
// - cancel wiring roughly halves hold range
// - add/delete output clocks divider, msb fed back
// - carry on overflow, borrow on underflow
// - each pulse adds or removes one pulse
//
// all-digital pll top: detector, modulus counter, add/delete, divider
// assumes the input signal and both loop clocks arrive as async pins
`timescale 1ns/1ps
`default_nettype none
module dpll_core
    import dpll_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // pins from outside the clock domain
    input wire logic signal_in,              // tracked input signal
    input wire logic modulus_counter_clock,  // modulus counter clock pin
    input wire logic add_delete_clock,       // add/delete stage clock pin
    // configuration
    input wire logic [1:0] mode,             // detector and wiring choice
    input wire logic [4:0] kexp,             // modulus exponent, 3 to 17
    input wire logic [DPLL_NW-1:0] n_top,    // divider terminal count, n minus one
    // outputs
    output logic loop_out,                   // feedback divider msb
    output logic add_delete_out,             // add/delete stage output
    output logic carry_seen,                 // carry pulse, one cycle
    output logic borrow_seen,                // borrow pulse, one cycle
    output logic [DPLL_NW-1:0] divider_count // full divider for inspection
);
    // ==========================================
    // synchronisers, two flops each before any logic
    logic [2:0] sync_a;   // first stage, read only by second stage
    logic [2:0] sync_b;   // second stage, safe to use
    logic kclk_prev;      // edge detect history
    logic dclk_prev;
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            sync_a <= 3'h0;
            sync_b <= 3'h0;
            kclk_prev <= 1'b0;
            dclk_prev <= 1'b0;
        end else begin
            sync_a <= {add_delete_clock, modulus_counter_clock, signal_in};
            sync_b <= sync_a;
            kclk_prev <= sync_b[1];
            dclk_prev <= sync_b[2];
        end
    end
    logic sig_s;
    logic ktick;   // rising edge of modulus counter clock
    logic dtick;   // rising edge of add/delete clock
    logic dfall;   // falling edge of add/delete clock
    assign sig_s = sync_b[0];
    assign ktick = sync_b[1] & ~kclk_prev;
    assign dtick = sync_b[2] & ~dclk_prev;
    assign dfall = ~sync_b[2] & dclk_prev;

    // ==========================================
    // phase detectors
    logic [DPLL_NW-1:0] ncount;   // feedback divider state
    logic msb;
    logic msb2;
    logic xor_pd;                 // xor detector output
    logic edge_pd;                // edge detector flip-flop
    logic sig_prev;
    logic msb_prev;
    dpll_mode_e mode_e;
    assign mode_e = dpll_mode_e'(mode);
    assign msb = ncount[DPLL_NW-1];
    assign msb2 = ncount[DPLL_NW-2];
    assign xor_pd = sig_s ^ msb;
    // edge detector: set on input rise, cleared on output rise
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            edge_pd <= 1'b0;
            sig_prev <= 1'b0;
            msb_prev <= 1'b0;
        end else begin
            sig_prev <= sig_s;
            msb_prev <= msb;
            // output edge wins a tie so the state stays defined
            if (msb && !msb_prev) begin
                edge_pd <= 1'b0;
            end else if (sig_s && !sig_prev) begin
                edge_pd <= 1'b1;
            end
        end
    end

    // ==========================================
    // counter wiring per mode
    logic k_enable;
    logic k_down;
    always_comb begin
        k_enable = 1'b1;
        k_down = xor_pd;
        case (mode_e)
            DPLL_MODE_XOR_DIRECT: begin
                // carry and borrow land in one half period and cancel
                k_enable = 1'b1;
                k_down = xor_pd;
            end
            DPLL_MODE_EDGE_DIRECT: begin
                // too small a modulus shows as msb duty ripple here
                k_enable = 1'b1;
                k_down = edge_pd;
            end
            DPLL_MODE_XOR_CANCEL: begin
                // detector gates counting; net count tracks error
                // zero error: equal up and down, average count steady
                // gating halves detector gain and roughly the hold range
                k_enable = xor_pd;
                k_down = msb2;
            end
            DPLL_MODE_EDGE_CANCEL: begin
                // count only while msb is low, so pulses fall in one half
                k_enable = ~msb;
                k_down = edge_pd;
            end
            default: begin
                k_enable = 1'b0;
                k_down = 1'b0;
            end
        endcase
    end

    // ==========================================
    // modulus counter instance
    logic carry;
    logic borrow;
    dpll_modulus_counter u_kcnt (
        .core_clk(core_clk),
        .resetn(resetn),
        .count_tick(ktick),
        .count_enable(k_enable),
        .count_down(k_down),
        .kexp(kexp),
        .carry(carry),
        .borrow(borrow),
        .count()
    );

    // ==========================================
    // add/delete stage: a pulse every second tick, carry adds, borrow deletes
    // pending flags keep a pulse that arrives between add/delete ticks
    // each pulse ends on the falling clock edge, so two ticks in a row
    // can both carry a pulse and the divider still sees two rising edges
    logic add_pend;
    logic del_pend;
    logic tff;          // nominal divide-by-two phase, low means a pulse is due
    logic dout;
    logic dout_prev;
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            add_pend <= 1'b0;
            del_pend <= 1'b0;
        end else begin
            // a new pulse wins over the clear in the same cycle
            if (carry) begin
                add_pend <= 1'b1;
            end else if (dtick && add_pend && tff) begin
                add_pend <= 1'b0;
            end
            if (borrow) begin
                del_pend <= 1'b1;
            end else if (dtick && del_pend && !tff) begin
                del_pend <= 1'b0;
            end
        end
    end
    // output phase: an add fires in the empty slot, a delete drops a due pulse
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            tff <= 1'b0;
            dout <= 1'b0;
        end else if (dtick) begin
            if (add_pend && tff) begin
                // extra pulse, phase held: output one tick earlier
                dout <= 1'b1;
            end else if (del_pend && !tff) begin
                // due pulse dropped, phase held: output one tick later
                dout <= 1'b0;
            end else begin
                tff <= ~tff;
                dout <= ~tff;
            end
        end else if (dfall) begin
            dout <= 1'b0;  // pulse lasts the high half of the clock
        end
    end

    // ==========================================
    // divide-by-n up counter clocked by add/delete output
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            dout_prev <= 1'b0;
            ncount <= DPLL_N_RST;
        end else begin
            dout_prev <= dout;
            if (dout && !dout_prev) begin
                // msb of this counter returns to the detectors
                if (ncount >= n_top) begin
                    ncount <= DPLL_N_RST;
                end else begin
                    ncount <= ncount + DPLL_NW'(1);
                end
            end
        end
    end

    // ==========================================
    // registered outputs
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            loop_out <= 1'b0;
            add_delete_out <= 1'b0;
            carry_seen <= 1'b0;
            borrow_seen <= 1'b0;
            divider_count <= DPLL_N_RST;
        end else begin
            loop_out <= msb;
            add_delete_out <= dout;
            carry_seen <= carry;
            borrow_seen <= borrow;
            divider_count <= ncount;
        end
    end
endmodule : dpll_core
`default_nettype wire

// ### verif/dpll_core_checker.sv
// checker holding the concurrent properties of the dpll core outputs
// assumes one core_clk domain and a steady n_top while the divider runs
`timescale 1ns/1ps
`default_nettype none
module dpll_core_checker
    import dpll_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic resetn,
    // configuration seen
    input wire logic [DPLL_NW-1:0] n_top,
    // outputs watched
    input wire logic loop_out,
    input wire logic add_delete_out,
    input wire logic carry_seen,
    input wire logic borrow_seen,
    input wire logic [DPLL_NW-1:0] divider_count
);
    // ==========================================
    // properties, all on core_clk
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    wire any_wrap = carry_seen | borrow_seen; // either counter wrap
    a_carry_pulse: assert property (carry_seen |=> !carry_seen)
        else $error("carry pulse longer than one cycle");
    a_borrow_pulse: assert property (borrow_seen |=> !borrow_seen)
        else $error("borrow pulse longer than one cycle");
    a_one_way: assert property (!(carry_seen && borrow_seen))
        else $error("carry and borrow together");
    // reload to half modulus means at least four ticks between wraps
    a_wrap_gap: assert property (any_wrap |=> !any_wrap [*8])
        else $error("wraps too close together");
    a_msb_out: assert property (loop_out == divider_count[DPLL_NW-1])
        else $error("loop output is not the divider msb");
    a_div_step: assert property ($changed(divider_count) |->
        (divider_count - $past(divider_count)) == 8'h01 || divider_count == 8'h00)
        else $error("divider did not count up by one");
    a_div_wrap: assert property ($changed(divider_count) && $stable(n_top) &&
        $past(divider_count) == n_top |-> divider_count == 8'h00)
        else $error("divider did not wrap at terminal count");
    a_reset_clear: assert property ($rose(resetn) |->
        !(any_wrap || loop_out || add_delete_out) && divider_count == 8'h00)
        else $error("outputs not clear after reset");
    c_carry: cover property (carry_seen);
    c_borrow: cover property (borrow_seen);
    c_msb_rise: cover property ($rose(loop_out));
endmodule : dpll_core_checker
bind dpll_core dpll_core_checker u_chk (.core_clk(core_clk), .resetn(resetn),
    .n_top(n_top), .loop_out(loop_out), .add_delete_out(add_delete_out),
    .carry_seen(carry_seen), .borrow_seen(borrow_seen), .divider_count(divider_count));
`default_nettype wire

// ### verif/dpll_signal_src.sv
// model of the tracked input signal source
// assumes the bench gives the half period in core_clk cycles
`timescale 1ns/1ps
`default_nettype none
module dpll_signal_src (
    // clock
    input wire logic core_clk,
    // control
    input wire logic run,
    input wire logic lvl,
    input wire logic [15:0] half,
    // output
    output logic sig
);
    int cnt = 0; // cycles into current half period
    initial sig = 1'b0;
    // ==========================================
    // held level, or square wave with equal halves
    always @(posedge core_clk) begin
        if (!run) begin
            sig <= lvl;
            cnt <= 0;
        end else if (cnt >= int'(half) - 1) begin
            sig <= !sig;
            cnt <= 0;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule : dpll_signal_src
`default_nettype wire

// ### verif/dpll_core_tb.sv
// self-checking bench for the dpll core, counter model compared per tick
// assumes dpll_signal_src as tracked source and the bound checker
`timescale 1ns/1ps
`default_nettype none
module dpll_core_tb;
    import dpll_pkg::*;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic src_run = 1'b0; // source free running
    logic src_lvl = 1'b0; // source held level
    logic kpin = 1'b0; // modulus counter clock pin
    logic apin = 1'b0; // add/delete clock pin
    logic linked = 1'b0; // both pins from one divider
    logic lo_q = 1'b0;
    logic [2:0] ph = 3'h0;
    logic [1:0] mode = 2'h0;
    logic [4:0] kexp = 5'h03;
    logic signal_in, loop_out, add_delete_out, carry_seen, borrow_seen;
    logic [DPLL_NW-1:0] divider_count;
    int n_fail = 0;
    int compares = 0;
    int n_carry = 0;
    int n_borrow = 0;
    int n_rise = 0;
    logic ad_q = 1'b0; // add/delete output, one cycle late
    int n_adr = 0; // add/delete output rising edges
    int r0 = 0; // msb rises at start of a loop run
    int e0 = 0; // add/delete edges at start of a scenario
    int cnt, exp_c = 0, exp_b = 0, ff; // counter model
    logic s;
    dpll_signal_src src (.core_clk(core_clk), .run(src_run), .lvl(src_lvl),
        .half(16'h0800), .sig(signal_in));
    dpll_core uut (.core_clk(core_clk), .resetn(resetn), .signal_in(signal_in),
        .modulus_counter_clock(kpin), .add_delete_clock(apin), .mode(mode),
        .kexp(kexp), .n_top(8'hFF), .loop_out(loop_out),
        .add_delete_out(add_delete_out), .carry_seen(carry_seen),
        .borrow_seen(borrow_seen), .divider_count(divider_count));
    initial forever #2.5 core_clk = ~core_clk;
    // ==========================================
    // pulse counters and linked pin divider
    always @(posedge core_clk) begin
        n_carry <= n_carry + int'(carry_seen);
        n_borrow <= n_borrow + int'(borrow_seen);
        lo_q <= loop_out;
        n_rise <= n_rise + int'(loop_out && !lo_q);
        ad_q <= add_delete_out;
        n_adr <= n_adr + int'(add_delete_out && !ad_q);
        if (linked) begin
            ph <= ph + 3'h1;
            kpin <= ph[2];
            apin <= ph[2];
        end
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("FAIL %s expected %0d seen %0d", what, exp, seen);
        end
    endtask : check
    task automatic final_report;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report
    task automatic do_reset;
        src_lvl <= 1'b0;
        resetn <= 1'b0;
        repeat (3) @(posedge core_clk);
        resetn <= 1'b1;
        cnt = int'(DPLL_KCNT_RST); // reset count, not half modulus
        ff = 0;
        s = 1'b0;
        repeat (4) @(posedge core_clk);
    endtask : do_reset
    // one modulus tick at a given input level, model stepped alongside
    task automatic tick(input logic lvl);
        int top;
        top = 1 << ((kexp < 5'h03) ? 3 : int'(kexp));
        if (lvl && !s) ff = 1; // edge detector set by input rise
        s = lvl;
        src_lvl <= lvl;
        repeat (4) @(posedge core_clk);
        kpin <= 1'b1;
        repeat (4) @(posedge core_clk);
        kpin <= 1'b0;
        if (mode != 2'h2 || s) begin
            if ((mode == 2'h0 && s) || (mode[0] && ff != 0)) begin
                if (cnt == 0) begin
                    exp_b++;
                    cnt = top / 2;
                end else cnt--;
            end else if (cnt >= top - 1) begin
                exp_c++;
                cnt = top / 2;
            end else cnt++;
        end
        repeat (5) @(posedge core_clk);
        check("carry", n_carry, exp_c);
        check("borrow", n_borrow, exp_b);
    endtask : tick
    // one add/delete clock period, slow enough for the synchronisers
    task automatic apulse;
        apin <= 1'b1;
        repeat (4) @(posedge core_clk);
        apin <= 1'b0;
        repeat (4) @(posedge core_clk);
    endtask : apulse
    // ==========================================
    // main sequence: counter per mode, then the closed loop
    initial begin
        void'($urandom(90372));
        for (int m = 0; m < 8; m++) begin
            mode <= 2'(m);
            kexp <= 5'(2 + $urandom % 3);
            do_reset;
            for (int i = 0; i < 20; i++) tick(1'b0);
            for (int i = 0; i < 20; i++) tick(1'b1);
            for (int i = 0; i < 30; i++) tick(1'($urandom));
        end
        // add/delete: nothing pending, one carry pending, one borrow pending
        for (int b = 0; b < 3; b++) begin
            mode <= 2'h0;
            kexp <= 5'h03;
            do_reset;
            if (b == 1) repeat (4) tick(1'b0); // one carry from the reset count
            if (b == 2) repeat (5) tick(1'b1); // one borrow from the reset count
            e0 = n_adr;
            // pulses due on odd ticks; a carry moves them one tick earlier,
            // a borrow one tick later: 8 ticks give 4 or 5, 9 ticks 5 or 4
            repeat ((b == 2) ? 9 : 8) apulse;
            check("add/delete pulses", n_adr - e0, (b == 1) ? 5 : 4);
            check("divider count", divider_count, (b == 1) ? 5 : 4);
        end
        for (int m = 0; m < 4; m++) begin
            mode <= 2'(m);
            kexp <= 5'h09;
            do_reset;
            r0 = n_rise;
            src_run <= 1'b1;
            linked <= 1'b1;
            repeat (9000) @(posedge core_clk);
            check("msb rises", n_rise - r0 >= 2, 1);
            src_run <= 1'b0;
            linked <= 1'b0;
        end
        final_report;
    end
    initial begin
        repeat (90000) @(posedge core_clk);
        n_fail++;
        final_report;
    end
endmodule : dpll_core_tb
`default_nettype wire
